/* File: rtl/rdl3_pkg.sv */
// Purpose: constants and carriers for the lane-3 configuration register pair
// Assumes: byte-wide register access from the serial interface logic
// Notes:   offsets are the register addresses seen by the serial host
package rdl3_pkg;
  localparam logic [7:0] RDL3_CTRL_OFS   = 8'h0B;
  localparam logic [7:0] RDL3_ENA_OFS    = 8'h0C;
  localparam logic [7:0] RDL3_CTRL_RST   = 8'h00;
  localparam logic [7:0] RDL3_ENA_RST    = 8'h00;
  localparam logic [7:0] RDL3_ENA_WMASK  = 8'h07;
  localparam int         RDL3_EQ_LSB     = 4;
  localparam int         RDL3_TXG_BIT    = 3;
  localparam int         RDL3_EQG_BIT    = 2;
  localparam int         RDL3_RXG_LSB    = 0;
  localparam int         RDL3_PEAK_BIT   = 2;
  localparam int         RDL3_EQOFF_BIT  = 1;
  localparam int         RDL3_DRVOFF_BIT = 0;
  localparam logic [1:0] RDL3_RXG_LOW    = 2'h0;
  localparam logic [1:0] RDL3_RXG_MID    = 2'h1;
  localparam logic [1:0] RDL3_RXG_RESERVED_BIT   = 2'h2;
  localparam logic [1:0] RDL3_RXG_HIGH   = 2'h3;

  // one-hot receive gain selection for the analog lane, all zero for the reserved code
  typedef struct packed {
    logic high;
    logic mid;
    logic low;
  } rdl3_rxg_t;

  // analog lane controls
  typedef struct packed {
    logic [2:0] equalizer_strength;
    logic       transmit_dc_gain;
    logic       equalizer_dc_gain_select;
    rdl3_rxg_t  rx_gain;
    logic       rx_gain_reserved;
    logic       driver_peaking_on;
    logic       equalizer_stage_off;
    logic       driver_stage_off;
  } rdl3_lane_t;
endpackage

/* File: rtl/rdl3_regs.sv */
// Function
// RULE1: bits 6..4 of the control register hold equalizer strength, 000 weakest and 111 strongest.
// RULE2: control bit 3 picks transmit dc gain, 0 gives 0 dB and 1 gives 6 dB.
// RULE3: control bit 2 picks equalizer dc gain, 0 gives -6 dB and 1 gives unity.
// RULE4: control bits 1..0 stand in for the receive gain strap: 00 low, 01 mid, 11 high.
// RULE5: receive gain code 10 is stored as written but decoded as reserved, selecting no gain.
// RULE6: control bit 7 is a read-write reserved bit with no function, reset to zero.
// RULE7: enable bit 2 turns on 6 dB of driver peaking when one.
// RULE8: enable bit 1 is an active-low equalizer stage enable, one turns the stage off.
// RULE9: enable bit 0 is an active-low driver stage enable, one turns the driver off.
// RULE10: enable bits 7..3 read zero and ignore writes.
// RULE11: reset clears both registers to zero.
// RULE12: the registers are the serial configuration path; straps act when no host is there.
// RULE13: the host should set control bit 2 so output amplitude matches input amplitude.
//
// Purpose: lane-3 control and enable registers of a four-lane linear redriver
// Assumes: i_wr_en and i_rd_en are one-cycle strobes from the serial interface logic
// Notes:   read data is registered, valid one cycle after i_rd_en
module rdl3_regs
  import rdl3_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_resetn,
  input  wire logic [7:0] i_addr,
  input  wire logic       i_wr_en,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_rd_en,
  input  wire logic       i_host_present,
  input  wire logic [1:0] i_rx_gain_strap,
  output rdl3_lane_t      o_lane,
  output logic [7:0]      o_rd_data,
  output logic            o_rd_valid
);

  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] ena_r;
  logic [7:0] ena_nxt;
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;
  logic       rd_valid_r;
  logic       rd_valid_nxt;
  rdl3_lane_t lane_r;
  rdl3_lane_t lane_nxt;
  logic [1:0] rxg_code;

  // decode a two-bit receive gain code; 10 selects nothing
  function automatic rdl3_rxg_t rxg_decode(input logic [1:0] code);
    rdl3_rxg_t g;
    g = '0;
    case (code)
      RDL3_RXG_LOW:  g.low  = 1'b1;
      RDL3_RXG_MID:  g.mid  = 1'b1;
      RDL3_RXG_HIGH: g.high = 1'b1;
      default:       g      = '0; // RULE5
    endcase
    return g;
  endfunction

  // register writes; all control bits are plain storage
  always_comb begin
    ctrl_nxt = ctrl_r;
    ena_nxt  = ena_r;
    if (i_wr_en && i_addr == RDL3_CTRL_OFS) begin
      ctrl_nxt = i_wr_data; // RULE1 RULE2 RULE3 RULE4 RULE6
    end else if (i_wr_en && i_addr == RDL3_ENA_OFS) begin
      ena_nxt = i_wr_data & RDL3_ENA_WMASK; // RULE10
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_valid_nxt = i_rd_en;
    rd_data_nxt  = rd_data_r;
    if (i_rd_en) begin
      if (i_addr == RDL3_CTRL_OFS) begin
        rd_data_nxt = ctrl_r;
      end else if (i_addr == RDL3_ENA_OFS) begin
        rd_data_nxt = ena_r; // RULE10
      end else begin
        rd_data_nxt = 8'h00;
      end
    end
  end

  // strap wins only when no serial host configures the lane
  assign rxg_code = i_host_present ? ctrl_r[RDL3_RXG_LSB +: 2] : i_rx_gain_strap; // RULE12

  // lane outputs follow the stored bits one cycle later, keeping them glitch-free
  always_comb begin
    lane_nxt                          = '0;
    lane_nxt.equalizer_strength       = ctrl_r[RDL3_EQ_LSB +: 3]; // RULE1
    lane_nxt.transmit_dc_gain         = ctrl_r[RDL3_TXG_BIT]; // RULE2
    lane_nxt.equalizer_dc_gain_select = ctrl_r[RDL3_EQG_BIT]; // RULE3
    lane_nxt.rx_gain                  = rxg_decode(rxg_code); // RULE4
    lane_nxt.rx_gain_reserved         = (rxg_code == RDL3_RXG_RESERVED_BIT); // RULE5
    lane_nxt.driver_peaking_on        = ena_r[RDL3_PEAK_BIT]; // RULE7
    lane_nxt.equalizer_stage_off      = ena_r[RDL3_EQOFF_BIT]; // RULE8
    lane_nxt.driver_stage_off         = ena_r[RDL3_DRVOFF_BIT]; // RULE9
  end

  // state registers
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_r     <= RDL3_CTRL_RST; // RULE11
      ena_r      <= RDL3_ENA_RST; // RULE11
      rd_data_r  <= 8'h00;
      rd_valid_r <= 1'b0;
      lane_r     <= '0;
    end else begin
      ctrl_r     <= ctrl_nxt;
      ena_r      <= ena_nxt;
      rd_data_r  <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
      lane_r     <= lane_nxt;
    end
  end

  assign o_lane     = lane_r;
  assign o_rd_data  = rd_data_r;
  assign o_rd_valid = rd_valid_r;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  sequence ctrl_write_s;
    i_wr_en && i_addr == RDL3_CTRL_OFS;
  endsequence

  sequence ctrl_read_s;
    !i_wr_en && i_rd_en && i_addr == RDL3_CTRL_OFS;
  endsequence

  eq_strength_a: assert property (ctrl_write_s |=> ##1 o_lane.equalizer_strength == $past(i_wr_data[6:4], 2))
    else $error("equalizer strength not applied"); // RULE1
  tx_gain_a: assert property (ctrl_write_s |=> ##1 o_lane.transmit_dc_gain == $past(i_wr_data[3], 2))
    else $error("transmit gain not applied"); // RULE2
  eq_gain_a: assert property (ctrl_write_s |=> ##1 o_lane.equalizer_dc_gain_select == $past(i_wr_data[2], 2))
    else $error("equalizer gain not applied"); // RULE3
  rxg_high_a: assert property ((i_host_present && ctrl_r[1:0] == 2'h3) |=> o_lane.rx_gain == 3'b100)
    else $error("receive gain high not decoded"); // RULE4
  rxg_reserved_bit_a: assert property ((rxg_code == 2'h2) |=> o_lane.rx_gain == 3'b000 && o_lane.rx_gain_reserved)
    else $error("reserved receive gain selected a gain"); // RULE5
  reserved_bit_bit_a: assert property (ctrl_write_s ##1 ctrl_read_s |=> o_rd_valid && o_rd_data[7] == $past(i_wr_data[7], 2))
    else $error("reserved bit not read back"); // RULE6
  peak_on_a: assert property ((i_wr_en && i_addr == RDL3_ENA_OFS) |=> ##1 o_lane.driver_peaking_on == $past(i_wr_data[2], 2))
    else $error("peaking not applied"); // RULE7
  stage_off_a: assert property ((i_wr_en && i_addr == RDL3_ENA_OFS) |=> ##1
      {o_lane.equalizer_stage_off, o_lane.driver_stage_off} == $past(i_wr_data[1:0], 2))
    else $error("stage enables not applied"); // RULE8 RULE9
  ena_upper_a: assert property ((i_rd_en && i_addr == RDL3_ENA_OFS) |=> o_rd_data[7:3] == 5'h00)
    else $error("enable upper bits not zero"); // RULE10
  reset_zero_a: assert property ($rose(i_resetn) |-> ctrl_r == 8'h00 && ena_r == 8'h00)
    else $error("registers not cleared by reset"); // RULE11

  // further steps of the register path, built from small named sequences
  sequence ena_write_s;
    i_wr_en && i_addr == RDL3_ENA_OFS;
  endsequence

  sequence ena_read_s;
    !i_wr_en && i_rd_en && i_addr == RDL3_ENA_OFS;
  endsequence

  sequence other_read_s;
    i_rd_en && i_addr != RDL3_CTRL_OFS && i_addr != RDL3_ENA_OFS;
  endsequence

  sequence host_code_s(logic [1:0] code);
    i_host_present && ctrl_r[1:0] == code;
  endsequence

  sequence strap_code_s(logic [1:0] code);
    !i_host_present && i_rx_gain_strap == code;
  endsequence

  // read strobe answers exactly one cycle later
  rd_valid_a: assert property (i_rd_en |=> o_rd_valid)
    else $error("read strobe not answered"); // RULE12

  // no strobe, no answer; valid is a single-cycle pulse
  rd_idle_a: assert property (!i_rd_en |=> !o_rd_valid)
    else $error("read valid without a strobe"); // RULE12

  // read data holds between reads so a slow host can still pick it up
  rd_hold_a: assert property (!i_rd_en |=> $stable(o_rd_data))
    else $error("read data moved without a read"); // RULE12

  // addresses outside the pair read as zero
  unmapped_read_a: assert property (other_read_s |=> o_rd_valid && o_rd_data == 8'h00)
    else $error("unmapped address read nonzero"); // RULE12

  // the whole control byte comes back, reserved code included
  ctrl_read_back_a: assert property (ctrl_write_s ##1 ctrl_read_s |=> o_rd_data == $past(i_wr_data, 2))
    else $error("control byte not read back"); // RULE4

  // only the three low enable bits survive a write
  ena_read_back_a: assert property (ena_write_s ##1 ena_read_s |=>
      o_rd_data == ($past(i_wr_data, 2) & RDL3_ENA_WMASK))
    else $error("enable byte not read back masked"); // RULE10

  // the upper enable bits never hold anything
  ena_ignore_a: assert property (ena_write_s |=> ena_r[7:3] == 5'h00)
    else $error("enable upper bits took a write"); // RULE10

  // a control write stores every bit as given
  ctrl_store_a: assert property (ctrl_write_s |=> ctrl_r == $past(i_wr_data))
    else $error("control write not stored"); // RULE4

  // the reserved bit is plain storage
  reserved_bit_store_a: assert property (ctrl_write_s |=> ctrl_r[7] == $past(i_wr_data[7]))
    else $error("reserved bit not stored"); // RULE6

  // the three writable enable bits are plain storage
  ena_store_a: assert property (ena_write_s |=> ena_r[2:0] == $past(i_wr_data[2:0]))
    else $error("enable write not stored"); // RULE7

  // control keeps its value unless written
  ctrl_hold_a: assert property (!(i_wr_en && i_addr == RDL3_CTRL_OFS) |=> $stable(ctrl_r))
    else $error("control changed without a write"); // RULE1

  // enable keeps its value unless written
  ena_hold_a: assert property (!(i_wr_en && i_addr == RDL3_ENA_OFS) |=> $stable(ena_r))
    else $error("enable changed without a write"); // RULE7

  // an enable write leaves the control byte alone
  ena_ctrl_apart_a: assert property (ena_write_s |=> $stable(ctrl_r))
    else $error("enable write touched control"); // RULE1

  // a control write leaves the enable byte alone
  ctrl_ena_apart_a: assert property (ctrl_write_s |=> $stable(ena_r))
    else $error("control write touched enable"); // RULE9

  // host code low selects the low gain
  rxg_low_a: assert property (host_code_s(2'h0) |=> o_lane.rx_gain == 3'b001)
    else $error("receive gain low not decoded"); // RULE4

  // host code mid selects the mid gain
  rxg_mid_a: assert property (host_code_s(2'h1) |=> o_lane.rx_gain == 3'b010)
    else $error("receive gain mid not decoded"); // RULE4

  // host reserved code flags itself and selects nothing
  host_reserved_bit_a: assert property (host_code_s(2'h2) |=> o_lane.rx_gain_reserved && o_lane.rx_gain == 3'b000)
    else $error("host reserved code misdecoded"); // RULE5

  // without a host the strap decides: low
  strap_low_a: assert property (strap_code_s(2'h0) |=> o_lane.rx_gain == 3'b001)
    else $error("strap low not decoded"); // RULE12

  // without a host the strap decides: mid
  strap_mid_a: assert property (strap_code_s(2'h1) |=> o_lane.rx_gain == 3'b010)
    else $error("strap mid not decoded"); // RULE12

  // without a host the strap decides: high
  strap_high_a: assert property (strap_code_s(2'h3) |=> o_lane.rx_gain == 3'b100)
    else $error("strap high not decoded"); // RULE12

  // strap reserved code selects nothing either
  strap_reserved_bit_a: assert property (strap_code_s(2'h2) |=> o_lane.rx_gain_reserved && o_lane.rx_gain == 3'b000)
    else $error("strap reserved code misdecoded"); // RULE5

  // valid codes never raise the reserved flag
  reserved_bit_flag_a: assert property ((rxg_code != 2'h2) |=> !o_lane.rx_gain_reserved)
    else $error("reserved flag on a valid code"); // RULE5

  // never two gains at once, so the analog side never sees a fight
  rxg_onehot_a: assert property ($onehot0(o_lane.rx_gain))
    else $error("two receive gains selected"); // RULE4

  // the equalizer stage enable bit alone reaches its own output
  eq_off_a: assert property (ena_write_s |=> ##1 o_lane.equalizer_stage_off == $past(i_wr_data[1], 2))
    else $error("equalizer stage enable not applied"); // RULE8

  // driver enable reaches the driver output
  drv_off_a: assert property (ena_write_s |=> ##1 o_lane.driver_stage_off == $past(i_wr_data[0], 2))
    else $error("driver stage enable not applied"); // RULE9

  // outputs leave reset at the all-zero, all-enabled state
  reset_out_a: assert property ($rose(i_resetn) |-> o_lane == '0 && !o_rd_valid && o_rd_data == 8'h00)
    else $error("outputs not cleared by reset"); // RULE11

endmodule

/* File: verif/rdl3_host_model.sv */
// Purpose: serial host stand-in driving the register strobes
// Assumes: requests change 1 ns after the rising edge
// Notes:   released address and data show the inverse of the last value
module rdl3_host_model
  import rdl3_pkg::*;
(
  input  wire logic       i_clk_sys,
  output logic [7:0]      o_addr,
  output logic            o_wr_en,
  output logic [7:0]      o_wr_data,
  output logic            o_rd_en
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus at time zero
  initial begin
    {o_addr, o_wr_data, o_wr_en, o_rd_en} = '0;
  end
  // one-cycle write strobe, the serial path being the normal config route
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys) #1;
    {o_addr, o_wr_data, o_wr_en} = {a, d, 1'b1};
    @(posedge i_clk_sys) #1;
    {o_addr, o_wr_data, o_wr_en} = {~a, ~d, 1'b0};
  endtask
  // write then read of one address on consecutive edges, no idle edge between
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys) #1;
    {o_addr, o_wr_data, o_wr_en} = {a, d, 1'b1};
    @(posedge i_clk_sys) #1;
    {o_wr_data, o_wr_en, o_rd_en} = {~d, 1'b0, 1'b1};
    @(posedge i_clk_sys) #1;
    {o_addr, o_rd_en} = {~a, 1'b0};
  endtask
  // one-cycle read strobe, answer sampled by the caller afterwards
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk_sys) #1;
    {o_addr, o_rd_en} = {a, 1'b1};
    @(posedge i_clk_sys) #1;
    {o_addr, o_rd_en} = {~a, 1'b0};
  endtask
endmodule

/* File: verif/tb_top.sv */
// Purpose: self-checking bench for the lane-3 register pair
// Assumes: host model drives strobes 1 ns after the rising edge
// Notes:   expected lane controls come from a local decode, not the design
module tb_top
  import rdl3_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic       hp = 1'b1;
  logic [1:0] strap = 2'h0;
  logic [7:0] addr, wr_data, rd_data;
  logic [7:0] c_m = 8'h00;
  logic [7:0] e_m = 8'h00;
  logic       wr_en, rd_en, rd_valid;
  rdl3_lane_t lane;
  int         mismatches = 0;
  int         n_tests = 0;
  always #5 clk = ~clk;
  rdl3_host_model rdl3_host_model_inst (.i_clk_sys(clk), .o_addr(addr), .o_wr_en(wr_en),
    .o_wr_data(wr_data), .o_rd_en(rd_en));
  rdl3_regs rdl3_regs_inst (.i_clk_sys(clk), .i_resetn(resetn), .i_addr(addr), .i_wr_en(wr_en),
    .i_wr_data(wr_data), .i_rd_en(rd_en), .i_host_present(hp), .i_rx_gain_strap(strap),
    .o_lane(lane), .o_rd_data(rd_data), .o_rd_valid(rd_valid));
  task automatic tally_and_finish();
    if (mismatches == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // independent decode; host code wins unless no host is present
  function automatic rdl3_lane_t exp_lane();
    logic [1:0] g;
    g = hp ? c_m[1:0] : strap;
    return '{c_m[6:4], c_m[3], c_m[2], '{g == 2'h3, g == 2'h1, g == 2'h0}, g == 2'h2, e_m[2], e_m[1], e_m[0]};
  endfunction
  // two edges let the write reach the lane outputs
  task automatic lane_chk();
    repeat (2) @(posedge clk);
    #1;
    check(16'(lane), 16'(exp_lane()));
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    rdl3_host_model_inst.rd(a);
    check({7'h00, rd_valid, rd_data}, {8'h01, exp});
  endtask
  // writes also update the expected contents; enable keeps bits 2..0 only
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    rdl3_host_model_inst.wr(a, d);
    if (a === RDL3_CTRL_OFS) c_m = d;
    if (a === RDL3_ENA_OFS) e_m = d & 8'h07;
  endtask
  task automatic t_reset();
    rd_chk(RDL3_CTRL_OFS, 8'h00);
    rd_chk(RDL3_ENA_OFS, 8'h00);
    lane_chk();
  endtask
  // every strength end, both gains, all receive codes and bit 7
  task automatic t_ctrl();
    logic [7:0] v [6] = '{8'h00, 8'h81, 8'h72, 8'hFF, 8'h0E, 8'hF5};
    foreach (v[i]) begin
      put(RDL3_CTRL_OFS, v[i]);
      lane_chk();
      rd_chk(RDL3_CTRL_OFS, v[i]);
    end
  endtask
  task automatic t_ena();
    logic [7:0] v [5] = '{8'hFF, 8'h01, 8'h02, 8'h04, 8'hF8};
    foreach (v[i]) begin
      put(RDL3_ENA_OFS, v[i]);
      lane_chk();
      rd_chk(RDL3_ENA_OFS, v[i] & 8'h07);
    end
  endtask
  // back-to-back write and read, as a busy host would issue them
  task automatic t_b2b();
    rdl3_host_model_inst.wr_rd(RDL3_CTRL_OFS, 8'hA6);
    c_m = 8'hA6;
    check({7'h00, rd_valid, rd_data}, {8'h01, c_m});
    rdl3_host_model_inst.wr_rd(RDL3_ENA_OFS, 8'hFD);
    e_m = 8'h05;
    check({7'h00, rd_valid, rd_data}, {8'h01, e_m});
    lane_chk();
  endtask
  // unmapped places, unity gain setup, then strap fallback without host
  task automatic t_misc();
    put(8'h0A, 8'h5A);
    rd_chk(RDL3_CTRL_OFS, c_m);
    rd_chk(8'h0D, 8'h00);
    put(RDL3_CTRL_OFS, 8'h04);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) #1;
      hp = 1'b0;
      strap = 2'(i);
      lane_chk();
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1;
    resetn = 1'b1;
    t_reset();
    t_ctrl();
    t_ena();
    t_b2b();
    t_misc();
    {resetn, hp, c_m, e_m} = '0;
    @(posedge clk) #1;
    {resetn, hp} = 2'h3;
    t_reset();
    tally_and_finish();
  end
  initial begin
    #50000;
    mismatches++;
    tally_and_finish();
  end
endmodule
